// ### rtl/fpc_pkg.sv
`default_nettype none
package fpc_pkg;

    // ----------------------------------------
    // datapath widths
    // ----------------------------------------
    localparam int unsigned IN_W    = 32;
    localparam int unsigned IN_FRAC = 16;
    localparam int unsigned ACC_W   = 64;
    localparam int unsigned OUT_W   = 32;
    localparam int unsigned WL_W    = 6;
    localparam int unsigned FL_W    = 5;
    localparam int unsigned SH_W    = 5;
    localparam int unsigned CNT_W   = 16;
    localparam int unsigned AW      = 12;

    localparam logic [ACC_W-1:0] ACC_ONE = 64'h0000_0000_0000_0001;
    localparam logic [WL_W-1:0]  WL_DEF  = 6'h10;
    localparam logic [WL_W-1:0]  WL_MAX  = 6'h20;
    localparam logic [WL_W-1:0]  WL_I8   = 6'h08;
    localparam logic [WL_W-1:0]  WL_I16  = 6'h10;
    localparam logic [WL_W-1:0]  WL_I32  = 6'h20;
    localparam logic [WL_W-1:0]  WL_ONE  = 6'h01;
    localparam logic [FL_W-1:0]  FL_DEF  = 5'h0A;
    localparam logic [FL_W-1:0]  FL_INT  = 5'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [AW-1:0] ADDR_STAT = 12'h004;
    localparam logic [AW-1:0] ADDR_LAST = 12'h008;
    localparam logic [AW-1:0] ADDR_DIN  = 12'h00C;

    // ----------------------------------------
    // modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        TGT_FIX  = 3'h0,
        TGT_I8   = 3'h1,
        TGT_U8   = 3'h2,
        TGT_I16  = 3'h3,
        TGT_U16  = 3'h4,
        TGT_I32  = 3'h5,
        TGT_U32  = 3'h6,
        TGT_BOOL = 3'h7
    } fpc_tgt_t;

    typedef enum logic [2:0] {
        RND_PINF = 3'h0,
        RND_ZERO = 3'h1,
        RND_MINF = 3'h2,
        RND_INF  = 3'h3,
        RND_CONV = 3'h4,
        TRN_MINF = 3'h5,
        TRN_ZERO = 3'h6
    } fpc_rnd_t;

    typedef enum logic [2:0] {
        OVF_SAT   = 3'h0,
        OVF_SATZ  = 3'h1,
        OVF_SYM   = 3'h2,
        OVF_WRAP  = 3'h3,
        OVF_WRSM  = 3'h4
    } fpc_ovf_t;

    // ----------------------------------------
    // register layouts
    // ----------------------------------------
    typedef struct packed {
        logic             isat;
        fpc_ovf_t         ovf;
        fpc_rnd_t         rnd;
        logic [FL_W-1:0]  fl;
        logic [WL_W-1:0]  wl;
        logic             sgn;
        fpc_tgt_t         tgt;
    } fpc_cfg_t;

    localparam int unsigned CFG_W = $bits(fpc_cfg_t);
    localparam fpc_cfg_t CFG_RST = '{isat: 1'b0, ovf: OVF_WRAP, rnd: TRN_MINF,
                                     fl: FL_DEF, wl: WL_DEF, sgn: 1'b1, tgt: TGT_FIX};

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [14:0]      rsv;
        logic             sticky;
    } fpc_stat_t;

endpackage
`default_nettype wire

// ### rtl/fpc_round.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_round (
    input  wire logic [fpc_pkg::IN_W-1:0]  x,
    input  wire logic [fpc_pkg::FL_W-1:0]  fl,
    input  wire fpc_pkg::fpc_rnd_t         mode,
    output logic [fpc_pkg::ACC_W-1:0]      q
);
    logic [fpc_pkg::ACC_W-1:0] xe;
    logic [fpc_pkg::ACC_W-1:0] base;
    logic [fpc_pkg::ACC_W-1:0] rem;
    logic [fpc_pkg::ACC_W-1:0] half;
    logic [fpc_pkg::SH_W-1:0]  sh;
    logic                      neg;
    logic                      nz;
    logic                      tie;
    logic                      above;
    logic                      up;

    // ----------------------------------------
    // floor quotient and discarded bits
    // ----------------------------------------
    always_comb begin
        xe   = {{(fpc_pkg::ACC_W-fpc_pkg::IN_W){x[fpc_pkg::IN_W-1]}}, x};
        neg  = x[fpc_pkg::IN_W-1];
        sh   = '0;
        rem  = '0;
        half = '0;
        if (fl >= fpc_pkg::IN_FRAC) begin
            // widening is exact, nothing to round
            base = xe << (fl - fpc_pkg::IN_FRAC);
        end else begin
            sh   = fpc_pkg::SH_W'(fpc_pkg::IN_FRAC - fl);
            base = $signed(xe) >>> sh;
            rem  = xe & ((fpc_pkg::ACC_ONE << sh) - fpc_pkg::ACC_ONE);
            half = fpc_pkg::ACC_ONE << (sh - 1'b1);
        end
        nz    = (rem != '0);
        tie   = nz && (rem == half);
        above = rem > half;
    end

    // ----------------------------------------
    // increment decision
    // ----------------------------------------
    always_comb begin
        case (mode)
            fpc_pkg::RND_PINF: up = above | tie;
            fpc_pkg::RND_ZERO: up = above | (tie & neg);
            fpc_pkg::RND_MINF: up = above;
            fpc_pkg::RND_INF:  up = above | (tie & ~neg);
            fpc_pkg::RND_CONV: up = above | (tie & base[0]);
            fpc_pkg::TRN_ZERO: up = nz & neg;
            default:           up = 1'b0;
        endcase
        // floor is already truncation to minus infinity, so that mode never carries
        q = base + {{(fpc_pkg::ACC_W-1){1'b0}}, up};
    end

endmodule
`default_nettype wire

// ### rtl/fpc_conv.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fpc_conv (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [fpc_pkg::AW-1:0]      paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        in_valid,
    input  wire logic [fpc_pkg::IN_W-1:0]    in_data,
    output logic                             out_valid,
    output logic [fpc_pkg::OUT_W-1:0]        out_data,
    output logic                             out_ovf
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        fpc_pkg::fpc_cfg_t            cfg;
        logic                         sticky;
        logic [fpc_pkg::CNT_W-1:0]    cnt;
        logic [fpc_pkg::OUT_W-1:0]    last;
        logic                         pend;
        logic [fpc_pkg::IN_W-1:0]     pend_d;
        logic                         s1_v;
        logic [fpc_pkg::ACC_W-1:0]    s1_q;
        logic [fpc_pkg::WL_W-1:0]     s1_wl;
        logic                         s1_sgn;
        fpc_pkg::fpc_ovf_t            s1_ovf;
        logic                         out_v;
        logic [fpc_pkg::OUT_W-1:0]    out_d;
        logic                         out_o;
        logic                         rdy;
        logic                         err;
        logic [31:0]                  rdata;
    } fpc_state_t;

    localparam fpc_state_t ST_RST = '{
        cfg:    fpc_pkg::CFG_RST,
        s1_ovf: fpc_pkg::OVF_WRAP,
        default: '0
    };

    fpc_state_t                  s_q;
    fpc_state_t                  s_d;

    // ----------------------------------------
    // sample source and effective format
    // ----------------------------------------
    logic                        smp_v;
    logic [fpc_pkg::IN_W-1:0]    smp;
    logic [fpc_pkg::WL_W-1:0]    e_wl;
    logic                        e_sgn;
    logic [fpc_pkg::FL_W-1:0]    e_fl;
    fpc_pkg::fpc_rnd_t           e_rnd;
    fpc_pkg::fpc_ovf_t           e_ovf;
    fpc_pkg::fpc_ovf_t           int_ovf;
    logic                        e_bool;
    logic [fpc_pkg::ACC_W-1:0]   rq;

    always_comb begin
        // streamed samples have priority; a software sample waits for a gap
        smp_v = in_valid | s_q.pend;
        smp   = in_valid ? in_data : s_q.pend_d;
    end

    always_comb begin
        int_ovf = s_q.cfg.isat ? fpc_pkg::OVF_SAT : fpc_pkg::OVF_WRAP;
        e_wl    = s_q.cfg.wl;
        e_sgn   = s_q.cfg.sgn;
        e_fl    = s_q.cfg.fl;
        e_rnd   = s_q.cfg.rnd;
        e_ovf   = s_q.cfg.ovf;
        e_bool  = 1'b0;
        case (s_q.cfg.tgt)
            fpc_pkg::TGT_FIX: begin
                // user format only honoured here
                e_wl = s_q.cfg.wl;
                e_fl = s_q.cfg.fl;
            end
            fpc_pkg::TGT_I8: begin
                e_wl = fpc_pkg::WL_I8;
                e_sgn = 1'b1;
            end
            fpc_pkg::TGT_U8: begin
                e_wl = fpc_pkg::WL_I8;
                e_sgn = 1'b0;
            end
            fpc_pkg::TGT_I16: begin
                e_wl = fpc_pkg::WL_I16;
                e_sgn = 1'b1;
            end
            fpc_pkg::TGT_U16: begin
                e_wl = fpc_pkg::WL_I16;
                e_sgn = 1'b0;
            end
            fpc_pkg::TGT_I32: begin
                e_wl = fpc_pkg::WL_I32;
                e_sgn = 1'b1;
            end
            fpc_pkg::TGT_U32: begin
                e_wl = fpc_pkg::WL_I32;
                e_sgn = 1'b0;
            end
            default: begin
                // boolean: any non-zero input is one, never overflows
                e_wl   = fpc_pkg::WL_MAX;
                e_sgn  = 1'b0;
                e_bool = 1'b1;
            end
        endcase
        if (s_q.cfg.tgt != fpc_pkg::TGT_FIX) begin
            // integer targets behave like a C cast
            e_fl  = fpc_pkg::FL_INT;
            e_rnd = fpc_pkg::TRN_ZERO;
            e_ovf = e_bool ? fpc_pkg::OVF_WRAP : int_ovf;
        end
    end

    fpc_round u_round (
        .x    (smp),
        .fl   (e_fl),
        .mode (e_rnd),
        .q    (rq)
    );

    // ----------------------------------------
    // range check and overflow handling
    // ----------------------------------------
    logic signed [fpc_pkg::ACC_W-1:0] qs;
    logic signed [fpc_pkg::ACC_W-1:0] maxv;
    logic signed [fpc_pkg::ACC_W-1:0] minv;
    logic        [fpc_pkg::ACC_W-1:0] wmask;
    logic        [fpc_pkg::ACC_W-1:0] wrapv;
    logic        [fpc_pkg::ACC_W-1:0] smv;
    logic        [fpc_pkg::WL_W-1:0]  wl_m1;
    logic                             hi;
    logic                             lo;
    logic                             ovf;
    logic        [fpc_pkg::ACC_W-1:0] res;

    always_comb begin
        qs    = $signed(s_q.s1_q);
        wl_m1 = s_q.s1_wl - fpc_pkg::WL_ONE;
        wmask = (fpc_pkg::ACC_ONE << s_q.s1_wl) - fpc_pkg::ACC_ONE;
        if (s_q.s1_sgn) begin
            // two's complement range
            maxv = $signed((fpc_pkg::ACC_ONE << wl_m1) - fpc_pkg::ACC_ONE);
            minv = -$signed(fpc_pkg::ACC_ONE << wl_m1);
        end else begin
            // non-negative only
            maxv = $signed(wmask);
            minv = '0;
        end
        hi  = qs > maxv;
        lo  = qs < minv;
        ovf = hi | lo;
        // plain wrap keeps the low bits, sign-extended when signed
        wrapv = s_q.s1_q & wmask;
        if (s_q.s1_sgn && wrapv[wl_m1]) begin
            wrapv = wrapv | ~wmask;
        end
        // sign-magnitude wrap: keep the original sign by inverting the bits
        smv = wrapv;
        if (s_q.s1_sgn && (wrapv[fpc_pkg::ACC_W-1] != s_q.s1_q[fpc_pkg::ACC_W-1])) begin
            smv = ~wrapv;
        end
        res = s_q.s1_q;
        if (ovf) begin
            case (s_q.s1_ovf)
                fpc_pkg::OVF_SAT: begin
                    res = hi ? maxv : minv;
                end
                fpc_pkg::OVF_SATZ: begin
                    res = '0;
                end
                fpc_pkg::OVF_SYM: begin
                    res = hi ? maxv : (s_q.s1_sgn ? -maxv : minv);
                end
                fpc_pkg::OVF_WRSM: begin
                    res = smv;
                end
                default: begin
                    res = wrapv;
                end
            endcase
        end
    end

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic                          hit_ctrl;
    logic                          hit_stat;
    logic                          hit_last;
    logic                          hit_din;

    always_comb begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        hit_last = 1'b0;
        hit_din  = 1'b0;
        if (paddr == fpc_pkg::ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == fpc_pkg::ADDR_STAT) begin
            hit_stat = 1'b1;
        end else if (paddr == fpc_pkg::ADDR_LAST) begin
            hit_last = 1'b1;
        end else if (paddr == fpc_pkg::ADDR_DIN) begin
            hit_din = 1'b1;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic                          acc;
    logic                          commit;
    logic                          clr;
    logic                          ev;
    fpc_pkg::fpc_cfg_t             wcfg;
    fpc_pkg::fpc_stat_t            stat;

    always_comb begin
        s_d    = s_q;
        acc    = psel && penable && !s_q.rdy;
        commit = psel && penable && s_q.rdy && pwrite && !s_q.err;
        clr    = 1'b0;
        ev     = s_q.s1_v && ovf;
        stat   = '{cnt: s_q.cnt, rsv: '0, sticky: s_q.sticky};
        wcfg   = fpc_pkg::fpc_cfg_t'(pwdata[fpc_pkg::CFG_W-1:0]);
        if (wcfg.wl == '0 || wcfg.wl > fpc_pkg::WL_MAX) begin
            wcfg.wl = fpc_pkg::WL_MAX;
        end

        // pipeline stage 1: round into the wide accumulator
        s_d.s1_v   = smp_v;
        s_d.s1_q   = e_bool ? {{(fpc_pkg::ACC_W-1){1'b0}}, smp != '0} : rq;
        s_d.s1_wl  = e_wl;
        s_d.s1_sgn = e_sgn;
        s_d.s1_ovf = e_ovf;
        if (!in_valid) begin
            s_d.pend = 1'b0;
        end

        // pipeline stage 2: registered result and its flag
        s_d.out_v = s_q.s1_v;
        s_d.out_o = ev;
        if (s_q.s1_v) begin
            s_d.out_d = res[fpc_pkg::OUT_W-1:0];
            s_d.last  = res[fpc_pkg::OUT_W-1:0];
        end

        // apb: answer one cycle into the access phase
        s_d.rdy   = acc;
        s_d.err   = 1'b0;
        s_d.rdata = '0;
        if (acc) begin
            if (hit_ctrl) begin
                s_d.rdata = {{(32-fpc_pkg::CFG_W){1'b0}}, s_q.cfg};
            end else if (hit_stat) begin
                s_d.rdata = stat;
            end else if (hit_last) begin
                s_d.rdata = s_q.last;
            end else if (hit_din) begin
                s_d.rdata = '0;
            end else begin
                s_d.err = 1'b1;
            end
        end
        if (commit) begin
            if (hit_ctrl) begin
                s_d.cfg = wcfg;
            end else if (hit_stat) begin
                clr = pwdata[0];
            end else if (hit_din) begin
                // a second write before the gap replaces the waiting sample
                s_d.pend   = 1'b1;
                s_d.pend_d = pwdata[fpc_pkg::IN_W-1:0];
            end
        end

        // overflow history: a new event beats a same-cycle clear
        if (clr) begin
            s_d.sticky = 1'b0;
            s_d.cnt    = '0;
        end
        if (ev) begin
            s_d.sticky = 1'b1;
            if (clr) begin
                s_d.cnt = fpc_pkg::CNT_ONE;
            end else if (s_q.cnt != fpc_pkg::CNT_MAX) begin
                s_d.cnt = s_q.cnt + fpc_pkg::CNT_ONE;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        prdata    = s_q.rdata;
        pready    = s_q.rdy;
        pslverr   = s_q.err;
        out_valid = s_q.out_v;
        out_data  = s_q.out_d;
        out_ovf   = s_q.out_o;
    end

endmodule
`default_nettype wire

// ### test/fpc_conv_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_conv_assertions (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [fpc_pkg::AW-1:0]    paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      in_valid,
    input wire logic [fpc_pkg::IN_W-1:0]  in_data,
    input wire logic                      out_valid,
    input wire logic [fpc_pkg::OUT_W-1:0] out_data,
    input wire logic                      out_ovf
);
    // ----------------------------------------
    // apb and datapath timing
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    assign acc    = psel && penable && !pready;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= fpc_pkg::ADDR_DIN);

    ready_after_access_a: assert property (acc |=> pready) else $error("no ready after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    err_unmapped_a: assert property (acc && !mapped |=> pslverr) else $error("unmapped access not refused");
    err_mapped_a: assert property (acc && mapped |=> !pslverr) else $error("mapped access refused");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    fixed_latency_a: assert property (in_valid |-> ##2 out_valid) else $error("result latency wrong");
    ovf_with_result_a: assert property (out_ovf |-> out_valid) else $error("overflow flag alone");
    result_hold_a: assert property (!out_valid |-> $stable(out_data)) else $error("result moved");

    cover property (acc && pwrite);
    cover property (pready && pslverr);
    cover property (out_valid && out_ovf);
    cover property (in_valid [*3]);
endmodule
bind fpc_conv fpc_conv_assertions fpc_conv_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_data(in_data), .out_valid(out_valid), .out_data(out_data), .out_ovf(out_ovf)
);
`default_nettype wire

// ### test/fpc_src.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_src (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     slow,
    output logic                          in_valid,
    output logic [fpc_pkg::IN_W-1:0]      in_data
);
    logic [31:0] q[$];
    logic        gap_q;
    task automatic push(input logic [31:0] x);
        q.push_back(x);
    endtask
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'h0;
            in_data  <= 32'h0;
            gap_q    <= 1'h0;
        end else begin
            gap_q <= slow && !gap_q;
            if (q.size() != 0 && !(slow && !gap_q)) begin
                in_valid <= 1'h1;
                in_data  <= q.pop_front();
            end else begin
                in_valid <= 1'h0;
                // idle bus toggles so no stale sample can pass as data
                in_data  <= ~in_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/fixed_point_type_converter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fixed_point_type_converter_tb_top;
    logic                   pclk, presetn, psel, penable, pwrite, slow, er;
    logic                   pready, pslverr, in_valid, out_valid, out_ovf;
    logic [fpc_pkg::AW-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd, in_data, out_data, rng_q, cfg, last_exp;
    logic [32:0]            exp_q[$];
    logic [32:0]            e;
    int                     err_total, compares, ovf_cnt, i, j, k;
    fpc_conv fpc_conv_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid), .out_data(out_data), .out_ovf(out_ovf));
    fpc_src fpc_src_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .in_valid(in_valid), .in_data(in_data));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q;
    endfunction
    task automatic conclude();
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [32:0] ex, input logic [32:0] got);
        compares++;
        if (got !== ex) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) begin
            chk("apb_wait", 33'h0, 33'h1);
            conclude();
        end
    endtask
    // ----------------------------------------
    // reference conversion, {ovf, data}
    // ----------------------------------------
    function automatic logic [32:0] ref_conv(input logic [31:0] c, input logic [31:0] x);
        longint v, f, r, h, lo, hi, m;
        int     s, w, t, om;
        logic   sg, o;
        t = c[2:0];
        if (t == 7) return {32'h0, x != 32'h0};
        if (t != 0) begin
            v  = longint'($signed(x)) / 64'sh10000;
            w  = (t <= 2) ? 8 : (t <= 4) ? 16 : 32;
            sg = t[0];
            om = c[21] ? 0 : 3;
        end else begin
            w  = (c[9:4] == 6'h00 || c[9:4] > 6'h20) ? 32 : c[9:4];
            sg = c[3];
            om = (c[20:18] > 3'h4) ? 3 : c[20:18];
            s  = 16 - c[14:10];
            v  = longint'($signed(x));
            if (s <= 0) v = v <<< -s;
            else begin
                f = v >>> s;
                r = v - (f <<< s);
                h = 64'sh1 <<< (s - 1);
                case (c[17:15])
                    3'h0: v = f + (r >= h);
                    3'h1: v = f + (r > h || (r == h && x[31]));
                    3'h2: v = f + (r > h);
                    3'h3: v = f + (r > h || (r == h && !x[31]));
                    3'h4: v = f + (r > h || (r == h && f[0]));
                    3'h6: v = f + (r != 0 && x[31]);
                    default: v = f;
                endcase
            end
        end
        m  = (64'sh1 <<< w) - 1;
        lo = sg ? -(64'sh1 <<< (w - 1)) : 0;
        hi = sg ? (64'sh1 <<< (w - 1)) - 1 : m;
        o  = v < lo || v > hi;
        if (o) begin
            if (om == 0) v = (v < lo) ? lo : hi;
            if (om == 1) v = 0;
            if (om == 2) v = (v < lo) ? (sg ? -hi : 0) : hi;
            if (om == 4) begin
                r = v & m;
                if (sg && r[w-1]) r -= (64'sh1 <<< w);
                v = (sg && ((r < 0) != (v < 0))) ? ~r : r;
            end
        end
        f = v & m;
        if (sg && f[w-1]) f |= ~m;
        return {o, f[31:0]};
    endfunction
    task automatic send(input logic [31:0] x);
        e = ref_conv(cfg, x);
        exp_q.push_back(e);
        last_exp = e[31:0];
        ovf_cnt += e[32];
        fpc_src_inst.push(x);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((exp_q.size() != 0 || fpc_src_inst.q.size() != 0) && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 300) begin
            chk("drain", 33'h0, 33'h1);
            conclude();
        end
    endtask
    task automatic set_cfg(input logic [31:0] c);
        cfg = c & 32'h003F_FFFF;
        if (cfg[9:4] == 6'h00 || cfg[9:4] > 6'h20) cfg[9:4] = 6'h20;
        apb(1'h1, fpc_pkg::ADDR_CTRL, c);
        apb(1'h0, fpc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", {1'h0, cfg}, {er, rd});
    endtask
    always @(posedge pclk) begin
        if (presetn === 1'h1 && out_valid === 1'h1) begin
            if (exp_q.size() == 0) chk("spurious", 33'h0, 33'h1);
            else chk("result", exp_q.pop_front(), {out_ovf, out_data});
        end
    end
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slow = 1'h0;
        rng_q = 32'h10;
        err_total = 0;
        compares = 0;
        ovf_cnt = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, fpc_pkg::ADDR_CTRL, 32'h0);
        cfg = 32'(fpc_pkg::CFG_RST);
        chk("ctrl_rst", {1'h0, cfg}, {er, rd});
        for (k = 0; k < 8; k++) send(xs());
        drain();
        for (i = 0; i < 7; i++) begin
            set_cfg({10'h0, 1'h0, 3'h3, 3'(i), 5'h02, 6'h06, 1'h1, 3'h0});
            send(32'h0002_A000);
            send(32'hFFFD_6000);
            send(32'h0002_BD71);
            send(32'h0002_E000);
            drain();
        end
        for (i = 0; i < 60; i++) begin
            set_cfg(xs());
            slow <= xs() & 32'h1;
            for (j = 0; j < 12; j++) begin
                rd = $signed(xs()) >>> (xs() % 20);
                if ((xs() & 32'h3) == 0) rd[15:0] = 16'h8000 >> cfg[14:10];
                send(rd);
            end
            drain();
        end
        apb(1'h0, fpc_pkg::ADDR_STAT, 32'h0);
        chk("stat", {1'h0, 16'(ovf_cnt), 15'h0, ovf_cnt != 0}, {er, rd});
        apb(1'h1, fpc_pkg::ADDR_STAT, 32'h1);
        apb(1'h0, fpc_pkg::ADDR_STAT, 32'h0);
        chk("stat_clr", 33'h0, {er, rd});
        apb(1'h1, fpc_pkg::ADDR_LAST, 32'h1234_5678);
        apb(1'h0, fpc_pkg::ADDR_LAST, 32'h0);
        chk("last", {1'h0, last_exp}, {er, rd});
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, fpc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_rst2", {1'h0, 32'(fpc_pkg::CFG_RST)}, {er, rd});
        apb(1'h0, fpc_pkg::ADDR_LAST, 32'h0);
        chk("last_rst", 33'h0, {er, rd});
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped", 33'h1_0000_0000, {er, rd});
        set_cfg(32'h0000_0000);
        e = ref_conv(cfg, 32'hFFFE_8000);
        exp_q.push_back(e);
        apb(1'h1, fpc_pkg::ADDR_DIN, 32'hFFFE_8000);
        drain();
        conclude();
    end
endmodule
`default_nettype wire
